// ==== hw/fcc_engine.v ====
// Notes on behaviour
// R1 - CRC-64 uses the degree-64 ECMA-182 generator polynomial.
// R2 - Data bytes enter least significant bit first; CRC starts at zero.
// R3 - Whole-array check: 9Bh, 27h, FFh, then eight expected CRC bytes.
// R4 - Range check: FEh, expected CRC, start then stop address, LSB first.
// R5 - Expected CRC arrives in bytes four to eleven, low byte first.
// R6 - Chip select rising after the last byte confirms and starts computing.
// R7 - Result compared with expected; pass or fail shown in flag bit 4.
// R8 - Computed CRC stored in readback only on fail; stays zero on pass.
// R9 - Command 96h reads the readback register, low byte first.
// R10 - Readback register is cleared when each CRC operation begins.
// R11 - Readback is volatile, cleared at power-up and every reset.
// R12 - Readback read advances per byte; after location 64 outputs 00h. The code outputs 00h from the ninth byte read (location 8) on.
// R13 - Chip select lifted before the full sequence starts no operation.
`timescale 1ns/1ps
`default_nettype none

`include "fcc_regs.vh"

module fcc_engine
(
    // System clock and reset
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        soft_rst,
    // Serial link from the host, sampled by clk_sys
    input  wire        spi_sclk,
    input  wire        spi_cs_b,
    input  wire        spi_mosi,
    output reg         spi_miso,
    output reg         spi_miso_oe,
    // Array read port
    output reg  [31:0] arr_addr,
    output reg         arr_rd,
    input  wire [7:0]  arr_data,
    input  wire        arr_valid,
    input  wire [31:0] arr_last_addr,
    // Status
    output reg         crc_busy,
    output reg         crc_fail_flag
);

    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_DONE = 2'd3;

    wire sclk_s;
    wire cs_b_s;
    wire mosi_s;

    fcc_sync u_sync_sclk (.clk_sys(clk_sys), .rst_b(rst_b),
                          .din(spi_sclk), .dout(sclk_s));
    // The select is carried inverted so that reset leaves it deselected.
    wire cs_sel_s;

    fcc_sync u_sync_cs   (.clk_sys(clk_sys), .rst_b(rst_b),
                          .din(~spi_cs_b), .dout(cs_sel_s));

    assign cs_b_s = ~cs_sel_s;
    fcc_sync u_sync_mosi (.clk_sys(clk_sys), .rst_b(rst_b),
                          .din(spi_mosi), .dout(mosi_s));

    reg        sclk_q;
    reg        cs_b_q;
    reg [7:0]  shift_q;
    reg [2:0]  bit_q;
    reg [4:0]  pos_q;
    reg        seq_ok_q;
    reg        range_q;
    reg        rb_mode_q;
    reg [6:0]  rb_loc_q;
    reg [7:0]  tx_q;
    reg [63:0] exp_q;
    reg [31:0] start_q;
    reg [31:0] stop_q;
    reg [63:0] crc_q;
    reg [63:0] rb_q;
    reg [1:0]  state_q;

    wire rise     = sclk_s & ~sclk_q;
    wire fall     = ~sclk_s & sclk_q;
    wire cs_rise  = cs_b_s & ~cs_b_q;
    wire [7:0] rx_byte = {shift_q[6:0], mosi_s};
    wire byte_done = rise & ~cs_b_s & (bit_q == 3'd7);
    wire [4:0] pos_next = pos_q + 5'd1;
    wire [63:0] crc_next;
    wire full_seq = seq_ok_q &&
                    (range_q ? (pos_q == `FCC_LEN_RANGE)
                             : (pos_q == `FCC_LEN_WHOLE));

    fcc_crc_step u_step (.crc_in(crc_q), .data(arr_data),
                         .crc_out(crc_next)); // R1 R2

    wire [63:0] rb_shift = rb_q >> {rb_loc_q[2:0], 3'b000};

    // Command receiver: bytes arrive MSB first on rising clock edges.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_q    <= 1'b0;
            cs_b_q    <= 1'b1;
            shift_q   <= 8'h00;
            bit_q     <= 3'd0;
            pos_q     <= 5'd0;
            seq_ok_q  <= 1'b0;
            range_q   <= 1'b0;
            rb_mode_q <= 1'b0;
            exp_q     <= 64'h0;
            start_q   <= 32'h0;
            stop_q    <= 32'h0;
        end
        else
        begin
            sclk_q <= sclk_s;
            cs_b_q <= cs_b_s;
            if (cs_b_s || soft_rst)
            begin
                bit_q     <= 3'd0;
                pos_q     <= 5'd0;
                rb_mode_q <= 1'b0;
                if (cs_b_s && !cs_rise)
                    seq_ok_q <= 1'b0;
            end
            else if (rise)
            begin
                shift_q <= rx_byte;
                bit_q   <= bit_q + 3'd1;
                if (byte_done && !rb_mode_q)
                begin
                    if (pos_q != 5'd31)
                        pos_q <= pos_next;
                    case (pos_next)
                        5'd1:
                        begin
                            seq_ok_q  <= (rx_byte == `FCC_CMD_ACTIVATE); // R3
                            rb_mode_q <= (rx_byte == `FCC_CMD_READBACK); // R9
                        end
                        5'd2:
                            seq_ok_q <= seq_ok_q &
                                        (rx_byte == `FCC_CMD_CRC_SUB); // R3
                        5'd3:
                        begin
                            range_q  <= (rx_byte == `FCC_OPT_RANGE); // R4
                            seq_ok_q <= seq_ok_q &
                                        ((rx_byte == `FCC_OPT_WHOLE) |
                                         (rx_byte == `FCC_OPT_RANGE));
                        end
                        default:
                        begin
                            if (pos_next >= `FCC_CRC_FIRST_POS &&
                                pos_next <= `FCC_CRC_LAST_POS)
                                exp_q <= {rx_byte, exp_q[63:8]}; // R5
                            else if (pos_next >= `FCC_START_POS &&
                                     pos_next < `FCC_STOP_POS)
                                start_q <= {rx_byte, start_q[31:8]}; // R4
                            else if (pos_next >= `FCC_STOP_POS &&
                                     pos_next <= `FCC_LEN_RANGE)
                                stop_q <= {rx_byte, stop_q[31:8]}; // R4
                        end
                    endcase
                end
            end
        end
    end

    // Readback output: driven on falling edges, low byte first.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rb_loc_q    <= 7'd0;
            tx_q        <= 8'h00;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else if (!rb_mode_q || cs_b_s)
        begin
            rb_loc_q    <= 7'd0;
            tx_q        <= rb_q[7:0];
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            spi_miso_oe <= 1'b1;
            if (fall)
            begin
                spi_miso <= tx_q[7];
                tx_q     <= {tx_q[6:0], 1'b0};
            end
            if (byte_done)
            begin
                // Locations count bytes; eight carry data, the rest zeros.
                if (rb_loc_q != `FCC_RB_LAST_LOC)
                    rb_loc_q <= rb_loc_q + 7'd1; // R12
                if (rb_loc_q < 7'd7)
                    tx_q <= rb_shift[15:8]; // R9 R12
                else
                    tx_q <= `FCC_IDLE_BYTE; // R12
            end
        end
    end

    // Computation engine: walks the array and feeds bytes to the CRC.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q       <= ST_IDLE;
            crc_q         <= `FCC_CRC_INIT;
            rb_q          <= 64'h0; // R11
            arr_addr      <= 32'h0;
            arr_rd        <= 1'b0;
            crc_busy      <= 1'b0;
            crc_fail_flag <= 1'b0;
        end
        else if (soft_rst)
        begin
            state_q       <= ST_IDLE;
            rb_q          <= 64'h0; // R11
            arr_rd        <= 1'b0;
            crc_busy      <= 1'b0;
            crc_fail_flag <= 1'b0;
        end
        else
        begin
            arr_rd <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (cs_rise && full_seq) // R6 R13
                    begin
                        crc_q    <= `FCC_CRC_INIT; // R2
                        rb_q     <= 64'h0; // R10
                        arr_addr <= range_q ? start_q : 32'h0;
                        crc_busy <= 1'b1;
                        state_q  <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    arr_rd  <= 1'b1;
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (arr_valid)
                    begin
                        crc_q <= crc_next; // R1 R2
                        if (arr_addr == (range_q ? stop_q : arr_last_addr))
                            state_q <= ST_DONE;
                        else
                        begin
                            arr_addr <= arr_addr + 32'h1;
                            state_q  <= ST_READ;
                        end
                    end
                end
                ST_DONE:
                begin
                    crc_busy      <= 1'b0;
                    crc_fail_flag <= (crc_q != exp_q); // R7
                    if (crc_q != exp_q)
                        rb_q <= crc_q; // R8
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== hw/fcc_regs.vh ====
`ifndef FCC_REGS_VH
`define FCC_REGS_VH

// Command bytes of the check sequence and the readback read, and the idle filler byte.
`define FCC_CMD_ACTIVATE   8'h9b
`define FCC_CMD_CRC_SUB    8'h27
`define FCC_OPT_WHOLE      8'hff
`define FCC_OPT_RANGE      8'hfe
`define FCC_CMD_READBACK   8'h96
`define FCC_IDLE_BYTE      8'h00

// Byte counts and byte positions of the two sequence forms.
`define FCC_LEN_WHOLE      5'd11
`define FCC_LEN_RANGE      5'd19
`define FCC_CRC_FIRST_POS  5'd4
`define FCC_CRC_LAST_POS   5'd11
`define FCC_START_POS      5'd12
`define FCC_STOP_POS       5'd16

// Readback register: 64 bits, locations past the last one read as 00h.
`define FCC_RB_LAST_LOC    7'd64

// CRC-64 generator, x^64 term implied.
`define FCC_CRC_POLY       64'h42f0e1eba9ea3693
`define FCC_CRC_INIT       64'h0000000000000000

// Flag status bit that carries the check result.
`define FCC_FSR_CRC_BIT    4

`endif

// ==== hw/fcc_sync.v ====
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for one level from outside the clock domain.
module fcc_sync
(
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_b,
    // Level in and out
    input  wire din,
    output reg  dout
);

    reg meta_q;

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ==== hw/fcc_crc_step.v ====
`timescale 1ns/1ps
`default_nettype none

`include "fcc_regs.vh"

// One byte of CRC-64, bits taken least significant first.
module fcc_crc_step
(
    // Running value and new byte
    input  wire [63:0] crc_in,
    input  wire [7:0]  data,
    // Updated value
    output wire [63:0] crc_out
);

    wire [63:0] stage [0:8];

    assign stage[0] = crc_in;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            wire fb;
            assign fb = stage[i][63] ^ data[i];
            assign stage[i+1] = {stage[i][62:0], 1'b0} ^
                                ({64{fb}} & `FCC_CRC_POLY);
        end
    endgenerate

    assign crc_out = stage[8];

endmodule

`default_nettype wire

// ==== verification/fcc_engine_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcc_engine_asserts
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        soft_rst,
    // Link and array
    input wire logic        spi_cs_b,
    input wire logic        spi_miso_oe,
    input wire logic [31:0] arr_addr,
    input wire logic        arr_rd,
    input wire logic        arr_valid,
    // Status
    input wire logic        crc_busy,
    input wire logic        crc_fail_flag
);
    logic [31:0] last_q;
    logic        seen_q;
    logic        pend_q;
    logic [9:0]  busy_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_q <= 32'h0;
            seen_q <= 1'b0;
            pend_q <= 1'b0;
            busy_q <= 10'h0;
        end
        else
        begin
            last_q <= arr_rd ? arr_addr : last_q;
            seen_q <= crc_busy & (seen_q | arr_rd);
            pend_q <= arr_rd | (pend_q & ~arr_valid);
            busy_q <= crc_busy ? busy_q + 10'h1 : 10'h0;
        end
    end
    chk_start_on_cs: assert property ($rose(crc_busy) |-> spi_cs_b && $past(spi_cs_b))
        else $error("check started while selected");
    chk_rd_in_busy: assert property (arr_rd |-> crc_busy)
        else $error("array read outside a check");
    chk_rd_one_out: assert property (arr_rd |-> !pend_q || arr_valid)
        else $error("array read before previous answer");
    chk_addr_step: assert property (arr_rd && seen_q |-> arr_addr == last_q + 32'h1)
        else $error("array address did not step by one");
    chk_flag_holds: assert property ($changed(crc_fail_flag) |-> $past(crc_busy) || $past(soft_rst))
        else $error("flag moved without a check");
    chk_soft_clears: assert property (soft_rst |=> !crc_busy && !crc_fail_flag)
        else $error("soft reset left busy or flag");
    chk_oe_needs_cs: assert property (spi_cs_b [*5] |-> !spi_miso_oe)
        else $error("output driven while deselected");
    chk_busy_bounded: assert property (busy_q < 10'd600)
        else $error("check never finished");
endmodule
bind fcc_engine fcc_engine_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .soft_rst(soft_rst), .spi_cs_b(spi_cs_b), .spi_miso_oe(spi_miso_oe),
    .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_valid(arr_valid),
    .crc_busy(crc_busy), .crc_fail_flag(crc_fail_flag));
`default_nettype wire

// ==== verification/fcc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcc_host_model
(
    // Clock
    input  wire logic clk_sys,
    // Serial link
    output var  logic spi_sclk,
    output var  logic spi_cs_b,
    output var  logic spi_mosi,
    input  wire logic spi_miso
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic half();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    // Clock idles low outside frames; data moves only while it is low.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
        begin
            spi_mosi = tx[i];
            half();
            spi_sclk = 1'b1;
            rx[i] = spi_miso;
            half();
            spi_sclk = 1'b0;
        end
    endtask
    task automatic sel();
        half();
        spi_cs_b = 1'b0;
        half();
    endtask
    // No wait after release, so a short check is not missed.
    task automatic desel();
        half();
        spi_cs_b = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcc_regs.vh"
module testbench;
    logic        clk_sys;
    logic        rst_b;
    logic        soft_rst;
    logic        spi_sclk;
    logic        spi_cs_b;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic [31:0] arr_addr;
    logic        arr_rd;
    logic [7:0]  arr_data;
    logic        arr_valid;
    logic        crc_busy;
    logic        crc_fail_flag;
    logic [7:0]  rx;
    logic [17:0] rows [0:3];
    integer      num_errors;
    integer      checks_done;
    integer      r;
    fcc_engine dut (.clk_sys(clk_sys), .rst_b(rst_b), .soft_rst(soft_rst),
        .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .arr_addr(arr_addr),
        .arr_rd(arr_rd), .arr_data(arr_data), .arr_valid(arr_valid),
        .arr_last_addr(32'h0000000f), .crc_busy(crc_busy),
        .crc_fail_flag(crc_fail_flag));
    fcc_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk),
        .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
    always @(posedge clk_sys)
    begin
        arr_valid <= #1 arr_rd;
        arr_data <= #1 arr_addr[7:0] ^ 8'h5a;
    end
    function automatic [63:0] crc_of(input [31:0] a, input [31:0] b);
        reg [63:0] c;
        reg [31:0] i;
        reg [7:0]  d;
        integer    k;
        c = `FCC_CRC_INIT;
        for (i = a; i <= b; i = i + 1)
        begin
            d = i[7:0] ^ 8'h5a;
            for (k = 0; k < 8; k = k + 1)
                c = {c[62:0], 1'b0} ^ ((c[63] ^ d[k]) ? `FCC_CRC_POLY : 64'h0);
        end
        crc_of = c;
    endfunction
    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h0, got}, {7'h0, exp});
    endtask
    task automatic wait_busy(input logic v);
        integer n;
        n = 0;
        while (crc_busy !== v && n < 3000)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        if (n == 3000)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t busy wait timed out", $time);
            stop_test();
        end
    endtask
    task automatic read_rb(input logic [63:0] exp);
        integer n;
        host.sel();
        host.xfer(`FCC_CMD_READBACK, rx);
        cmp_bit(spi_miso_oe, 1'b1);
        for (n = 0; n < 9; n = n + 1)
        begin
            host.xfer(8'h00, rx);
            cmp_byte(rx, n < 8 ? exp[8*n +: 8] : `FCC_IDLE_BYTE);
        end
        host.desel();
    endtask
    task automatic check_op(input logic rng, input logic [31:0] a,
                            input logic [31:0] b, input logic bad);
        logic [63:0] crc;
        logic [63:0] exp;
        integer      n;
        crc = crc_of(a, b);
        exp = crc ^ {63'h0, bad};
        host.sel();
        host.xfer(`FCC_CMD_ACTIVATE, rx);
        host.xfer(`FCC_CMD_CRC_SUB, rx);
        host.xfer(rng ? `FCC_OPT_RANGE : `FCC_OPT_WHOLE, rx);
        for (n = 0; n < 8; n = n + 1)
            host.xfer(exp[8*n +: 8], rx);
        for (n = 0; n < 8 && rng; n = n + 1)
            host.xfer(n < 4 ? a[8*n +: 8] : b[8*n-32 +: 8], rx);
        host.desel();
        wait_busy(1'b1);
        wait_busy(1'b0);
        cmp_bit(crc_fail_flag, bad);
        read_rb(bad ? crc : 64'h0);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        num_errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        soft_rst = 1'b0;
        arr_valid = 1'b0;
        arr_data = 8'h00;
        rows[0] = {1'b0, 8'h00, 8'h0f, 1'b1};
        rows[1] = {1'b0, 8'h00, 8'h0f, 1'b0};
        rows[2] = {1'b1, 8'h05, 8'h05, 1'b1};
        rows[3] = {1'b1, 8'h03, 8'h09, 1'b0};
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        for (r = 0; r < 4; r = r + 1)
            check_op(rows[r][17], {24'h0, rows[r][16:9]},
                     {24'h0, rows[r][8:1]}, rows[r][0]);
        // A sequence one byte short must not start a check.
        host.sel();
        host.xfer(`FCC_CMD_ACTIVATE, rx);
        host.xfer(`FCC_CMD_CRC_SUB, rx);
        for (r = 0; r < 8; r = r + 1)
            host.xfer(`FCC_OPT_WHOLE, rx);
        host.desel();
        repeat (20) @(posedge clk_sys);
        #1;
        cmp_bit(crc_busy, 1'b0);
        check_op(1'b0, 32'h0, 32'hf, 1'b1);
        soft_rst = 1'b1;
        @(posedge clk_sys);
        #1;
        soft_rst = 1'b0;
        cmp_bit(crc_fail_flag, 1'b0);
        read_rb(64'h0);
        check_op(1'b1, 32'h5, 32'h5, 1'b1);
        rst_b = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        read_rb(64'h0);
        stop_test();
    end
endmodule
`default_nettype wire
